// ==== src/crc_params.svh ====
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// register byte offsets
`define CRC_CTRL_OFS 4'h0
`define CRC_LIMIT_OFS 4'h4
`define CRC_STAT_OFS 4'h8
`define CRC_ACCUM_OFS 4'hC

// control register fields
`define CRC_EN_BIT 0
`define CRC_RST_BIT 1
`define CRC_BEH_LSB 2
`define CRC_BEH_MSB 3

// status register fields
`define CRC_FLAG_BIT 0
`define CRC_ALERT_BIT 1
`define CRC_ACTIVE_BIT 2

// reset values
`define CRC_EN_RST 1'h0
`define CRC_BEH_RST 2'h1
`define CRC_LIMIT_RST 16'h0000

// timing: one accumulation tick per millisecond
`define CRC_TICK_NS 1000000
`define CRC_CLK_NS 20

// milliampere-milliseconds in one milliampere-hour
`define CRC_MAH_UNITS 22'h36_EE80

`endif

// ==== src/crc_pkg.sv ====
`default_nettype none
package crc_pkg;

   typedef enum logic [1:0]
   {
      BEH_REPORT = 2'h0,
      BEH_RDISC = 2'h1,
      BEH_SLEEP = 2'h2,
      BEH_IGNORE = 2'h3
   } crc_beh_t;

   typedef enum logic [1:0]
   {
      ST_COUNT = 2'h1,
      ST_REACHED = 2'h2
   } crc_state_t;

endpackage : crc_pkg
`default_nettype wire

// ==== src/crc_accum.sv ====
`include "crc_params.svh"
`default_nettype none
module crc_accum #(
   parameter int unsigned TICK_CYCLES = `CRC_TICK_NS / `CRC_CLK_NS
)(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic clear_i,
   input wire logic [11:0] current_ma_i,
   output logic [15:0] charge_mah_o
);
   import crc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick divider
   logic [31:0] div_q, div_d;
   logic tick;

   always_comb
   begin
      tick = (div_q == TICK_CYCLES - 1);
      div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         div_q <= 32'h0000_0000;
      else
         div_q <= div_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // current times time, carried into whole mAh
   logic [21:0] frac_q, frac_d;
   logic [15:0] mah_q, mah_d;
   logic [22:0] sum;

   always_comb
   begin
      frac_d = frac_q;
      mah_d = mah_q;
      sum = {1'b0, frac_q} + {11'h000, current_ma_i};
      if (clear_i)
      begin
         frac_d = 22'h00_0000;
         mah_d = 16'h0000;
      end
      else if (run_i && tick)
      begin
         if (sum >= {1'b0, `CRC_MAH_UNITS})
         begin
            frac_d = 22'(sum - {1'b0, `CRC_MAH_UNITS});
            if (mah_q != 16'hFFFF)
               mah_d = mah_q + 16'h0001;
         end
         else
            frac_d = sum[21:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         frac_q <= 22'h00_0000;
         mah_q <= 16'h0000;
      end
      else
      begin
         frac_q <= frac_d;
         mah_q <= mah_d;
      end
   end

   assign charge_mah_o = mah_q;

endmodule : crc_accum
`default_nettype wire

// ==== src/crc_top.sv ====
// Overview of operation
// R01: host programs charge limit in mAh
// R02: accumulate and check only in Active state
// R03: integrate bus current over elapsed time
// R04: threshold never forces the Error state
// R05: hold threshold behaviour until reset or disable
// R06: two-bit behaviour select, default report+disconnect
// R07: report asserts alert; disconnect also opens switch
// R08: report+disconnect leaves data switch and monitors
// R09: pins still move state; switches stay off
// R10: sleep mode opens switch, enters Sleep, no alert
// R11: sleep mode disables data switch and monitoring
// R12: sleep mode freezes control inputs until reset; the code also releases it on disable or on a write of another behaviour
// R13: reset clears charge and reached flag
// R14: reset releases alert in report modes
// R15: reset in disconnect modes rechecks control pins
// R16: changed pins restart emulation if enabled
// R17: unchanged pins resume state, no restart
// R18: flag sets when charge reaches limit
// R19: reset write zeroes charge, counting resumes
// R20: disable clears charge registers
// R21: attach/removal keeps charge; emulation restarts
`include "crc_params.svh"
`default_nettype none
module crc_top #(
   parameter int unsigned TICK_CYCLES = `CRC_TICK_NS / `CRC_CLK_NS
)(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic active_state_i,
   input wire logic attach_detect_i,
   input wire logic [11:0] bus_current_ma_i,
   input wire logic mode_select_a_i,
   input wire logic mode_select_b_i,
   input wire logic emulation_enable_in_i,
   input wire logic system_state_in_i,
   input wire logic port_power_enable_in_i,
   output logic alert_n_o,
   output logic port_switch_off_o,
   output logic bypass_inhibit_o,
   output logic emulation_remove_o,
   output logic sleep_request_o,
   output logic hs_switch_disable_o,
   output logic monitor_stop_o,
   output logic control_freeze_o,
   output logic power_reeval_o,
   output logic emulation_restart_o
);
   import crc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // control pin synchronisers
   logic [4:0] pin_raw, pin_meta_q, pin_sync_q;

   assign pin_raw = {port_power_enable_in_i, system_state_in_i, emulation_enable_in_i,
                     mode_select_b_i, mode_select_a_i};

   generate
      for (genvar gi = 0; gi < 5; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               pin_meta_q[gi] <= 1'b0;
               pin_sync_q[gi] <= 1'b0;
            end
            else
            begin
               pin_meta_q[gi] <= pin_raw[gi];
               pin_sync_q[gi] <= pin_meta_q[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle per access
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_take;
   logic en_q, en_d;
   crc_beh_t beh_q, beh_d;
   logic [15:0] limit_q, limit_d;
   logic rst_cmd;
   crc_state_t state_q, state_d;
   logic alert_n_q, alert_n_d;
   logic [15:0] charge_mah;

   assign wr_take = avs_write_i & ~wait_q;

   always_comb
   begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if ((avs_read_i || avs_write_i) && wait_q)
         wait_d = 1'b0;
      if (avs_read_i && wait_q)
      begin
         case (avs_address_i)
            `CRC_CTRL_OFS: rdata_d = {28'h000_0000, beh_q, 1'b0, en_q};
            `CRC_LIMIT_OFS: rdata_d = {16'h0000, limit_q};
            `CRC_STAT_OFS: rdata_d = {29'h0000_0000, active_state_i, ~alert_n_q,
                                      state_q == ST_REACHED};
            `CRC_ACCUM_OFS: rdata_d = {16'h0000, charge_mah};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always_comb
   begin
      en_d = en_q;
      beh_d = beh_q;
      limit_d = limit_q;
      rst_cmd = 1'b0;
      if (wr_take && avs_address_i == `CRC_CTRL_OFS && avs_byteenable_i[0])
      begin
         en_d = avs_writedata_i[`CRC_EN_BIT];
         beh_d = crc_beh_t'(avs_writedata_i[`CRC_BEH_MSB:`CRC_BEH_LSB]); // R06
         rst_cmd = avs_writedata_i[`CRC_RST_BIT]; // R19
      end
      if (wr_take && avs_address_i == `CRC_LIMIT_OFS) // R01
      begin
         if (avs_byteenable_i[0])
            limit_d[7:0] = avs_writedata_i[7:0];
         if (avs_byteenable_i[1])
            limit_d[15:8] = avs_writedata_i[15:8];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         en_q <= `CRC_EN_RST;
         beh_q <= crc_beh_t'(`CRC_BEH_RST);
         limit_q <= `CRC_LIMIT_RST;
      end
      else
      begin
         en_q <= en_d;
         beh_q <= beh_d;
         limit_q <= limit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // charge accumulation
   logic acc_run, acc_clear;

   assign acc_run = en_q & active_state_i & (state_q == ST_COUNT); // R02
   assign acc_clear = rst_cmd | ~en_q; // R13 R19 R20 R21

   crc_accum #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_accum (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .run_i(acc_run), // R03
      .clear_i(acc_clear),
      .current_ma_i(bus_current_ma_i),
      .charge_mah_o(charge_mah)
   );

   ////////////////////////////////////////////////////////////////////////////
   // threshold state and recovery
   logic [4:0] snap_q, snap_d;
   logic hit, reached, disc_old, recheck, changed;
   logic sw_off_q, sw_off_d, byp_q, byp_d, emrm_q, emrm_d;
   logic sleep_q, sleep_d, reeval_q, reeval_d, restart_q, restart_d;

   always_comb
   begin
      hit = acc_run && (charge_mah >= limit_q); // R18
      disc_old = (beh_q == BEH_RDISC) || (beh_q == BEH_SLEEP);
      changed = (pin_sync_q != snap_q);
      recheck = (state_q == ST_REACHED) && disc_old &&
                (rst_cmd || !en_d || (beh_d != beh_q && beh_d != BEH_SLEEP)); // R15
      snap_d = hit ? pin_sync_q : snap_q;
      case (state_q)
         ST_COUNT: state_d = hit ? ST_REACHED : ST_COUNT;
         ST_REACHED: state_d = (rst_cmd || !en_d) ? ST_COUNT : ST_REACHED; // R05 R13
         default: state_d = ST_COUNT;
      endcase
      reached = (state_d == ST_REACHED);
      // threshold only steers these lines, never the error path
      alert_n_d = !(reached && (beh_d == BEH_REPORT || beh_d == BEH_RDISC)); // R04 R07 R14
      sw_off_d = reached && (beh_d == BEH_RDISC || beh_d == BEH_SLEEP); // R07 R10
      emrm_d = sw_off_d; // R07 R10
      byp_d = reached && beh_d == BEH_RDISC; // R08 R09
      sleep_d = reached && beh_d == BEH_SLEEP; // R10 R11 R12
      reeval_d = recheck && changed; // R15 R17
      restart_d = (reeval_d && pin_sync_q[2]) || // R16
                  (attach_detect_i && en_q && state_q == ST_COUNT); // R21
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_COUNT;
         snap_q <= 5'h00;
         alert_n_q <= 1'b1;
         sw_off_q <= 1'b0;
         emrm_q <= 1'b0;
         byp_q <= 1'b0;
         sleep_q <= 1'b0;
         reeval_q <= 1'b0;
         restart_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         snap_q <= snap_d;
         alert_n_q <= alert_n_d;
         sw_off_q <= sw_off_d;
         emrm_q <= emrm_d;
         byp_q <= byp_d;
         sleep_q <= sleep_d;
         reeval_q <= reeval_d;
         restart_q <= restart_d;
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o = rdata_q;
   assign alert_n_o = alert_n_q;
   assign port_switch_off_o = sw_off_q;
   assign bypass_inhibit_o = byp_q;
   assign emulation_remove_o = emrm_q;
   assign sleep_request_o = sleep_q;
   assign hs_switch_disable_o = sleep_q;
   assign monitor_stop_o = sleep_q;
   assign control_freeze_o = sleep_q;
   assign power_reeval_o = reeval_q;
   assign emulation_restart_o = restart_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_reset_write;
      wr_take && avs_address_i == `CRC_CTRL_OFS && avs_byteenable_i[0] &&
      avs_writedata_i[`CRC_RST_BIT] && !hit;
   endsequence

   sequence s_recheck_changed;
      recheck && changed;
   endsequence

   sequence s_bus_request;
      (avs_read_i || avs_write_i) && wait_q;
   endsequence

   alert_report_a: assert property ( // R07
      state_q == ST_COUNT && hit && beh_q == BEH_REPORT && !rst_cmd &&
      beh_d == beh_q && en_d |=> !alert_n_o && port_switch_off_o == 1'b0)
      else $error("alert not raised in report mode");

   sleep_no_alert_a: assert property ( // R10
      sleep_request_o |-> alert_n_o && port_switch_off_o && emulation_remove_o)
      else $error("sleep mode outputs inconsistent");

   gate_inactive_a: assert property ( // R02
      !active_state_i && en_q && !rst_cmd |=> $stable(charge_mah))
      else $error("charge moved outside active state");

   flag_set_a: assert property ( // R18
      hit |=> state_q == ST_REACHED)
      else $error("reached flag not set at limit");

   reset_clear_a: assert property ( // R13
      s_reset_write |=> state_q == ST_COUNT ##1 charge_mah == 16'h0000)
      else $error("reset did not clear charge and flag");

   freeze_hold_a: assert property ( // R12
      sleep_request_o && en_q && !rst_cmd && en_d && beh_d == BEH_SLEEP |=> sleep_request_o)
      else $error("sleep released without reset");

   recheck_pulse_a: assert property ( // R15
      s_recheck_changed |=> power_reeval_o ##1 !power_reeval_o)
      else $error("changed pins not re-evaluated");

   resume_quiet_a: assert property ( // R17
      recheck && !changed && !attach_detect_i |=> !power_reeval_o && !emulation_restart_o)
      else $error("resume caused a restart");

   bus_answer_a: assert property (
      s_bus_request |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle");

endmodule : crc_top
`default_nettype wire

// ==== tb/crc_dev_model.sv ====
`default_nettype none
module crc_dev_model
(
   input wire logic sys_clk_i,
   input wire logic plug_i,
   input wire logic [11:0] draw_ma_i,
   output logic attach_o,
   output logic [11:0] current_ma_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic plug_q;
   initial
   begin
      plug_q = 1'b0;
      attach_o = 1'b0;
      current_ma_o = 12'h000;
   end
   // draws only while plugged; pulse on plug-in
   always @(posedge sys_clk_i)
   begin
      plug_q <= plug_i;
      attach_o <= plug_i & ~plug_q;
      current_ma_o <= plug_i ? draw_ma_i : 12'h000;
   end
endmodule : crc_dev_model
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import crc_pkg::*;
   typedef struct packed {logic [1:0] beh; logic [6:0] exp; logic [2:0] st;} crc_row_t;
   crc_row_t rows [4] = '{'{2'h0, 7'h00, 3'h7}, '{2'h1, 7'h30, 3'h7},
                          '{2'h2, 7'h7F, 3'h5}, '{2'h3, 7'h40, 3'h5}};
   logic sys_clk_i, rst_n_i, rd, wr, wt, act, att, ma, mb, emu, s0, pwr, plug;
   logic an, off, byp, rem, slp, hs, mon, frz, reev, remu;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, rd_v;
   logic [11:0] cur, draw;
   int errors, compares, n_re, n_em, n;
   wire logic [6:0] outs = {an, off, rem, slp, hs, mon, frz};
   crc_top #(.TICK_CYCLES(10)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
      .active_state_i(act), .attach_detect_i(att), .bus_current_ma_i(cur),
      .mode_select_a_i(ma), .mode_select_b_i(mb), .emulation_enable_in_i(emu),
      .system_state_in_i(s0), .port_power_enable_in_i(pwr), .alert_n_o(an),
      .port_switch_off_o(off), .bypass_inhibit_o(byp), .emulation_remove_o(rem),
      .sleep_request_o(slp), .hs_switch_disable_o(hs), .monitor_stop_o(mon),
      .control_freeze_o(frz), .power_reeval_o(reev), .emulation_restart_o(remu));
   crc_dev_model model (.sys_clk_i(sys_clk_i), .plug_i(plug), .draw_ma_i(draw),
      .attach_o(att), .current_ma_o(cur));
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wr <= we;
      rd <= ~we;
      wdata <= d;
      do
      begin
         @(posedge sys_clk_i);
      end
      while (wt !== 1'b0);
      rd_v = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, rd_v, exp);
   endtask : rchk
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk_i);
   endtask : tick
   ////////////////////////////////////////////////////////////////////////////
   // pulse counters
   always @(posedge sys_clk_i)
   begin
      if (reev === 1'b1)
         n_re++;
      if (remu === 1'b1)
         n_em++;
   end
   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      tick(40000);
      errors++;
      finish_test;
   end
   initial
   begin
      {rst_n_i, rd, wr, ma, mb, emu, s0, plug} = 8'h00;
      {act, pwr} = 2'h3;
      addr = 4'h0;
      wdata = 32'h0000_0000;
      draw = 12'h000;
      tick(2);
      chk("reset_outs", {an, off, byp, rem, slp, reev, remu, wt}, 8'h81);
      rst_n_i <= 1'b1;
      rchk("ctrl_rst", 4'h0, 32'h0000_0004);
      rchk("limit_rst", 4'h4, 32'h0000_0000);
      rchk("unmapped", 4'h2, 32'h0000_0000);
      act <= 1'b0;
      bus(1'b1, 4'h0, 32'h0000_0001);
      tick(4);
      rchk("inactive", 4'h8, 32'h0000_0000);
      chk("inactive_outs", outs, 7'h40);
      bus(1'b1, 4'h0, 32'h0000_0000);
      act <= 1'b1;
      foreach (rows[i])
      begin
         bus(1'b1, 4'h0, {28'h000_0000, rows[i].beh, 2'h1});
         tick(4);
         chk("behaviour", outs, rows[i].exp);
         rchk("flag_set", 4'h8, {29'h0000_0000, rows[i].st});
         bus(1'b1, 4'h0, {28'h000_0000, rows[i].beh, 2'h0});
         tick(3);
         chk("released", outs, 7'h40);
         chk("no_recheck", n_re + n_em, 0);
      end
      // sleep: pins move while frozen, recheck on disable
      bus(1'b1, 4'h0, 32'h0000_0009);
      tick(4);
      ma <= 1'b1;
      emu <= 1'b1;
      tick(6);
      chk("frozen", {slp, frz, reev}, 3'h6);
      bus(1'b1, 4'h0, 32'h0000_0008);
      tick(3);
      chk("reeval", n_re, 1);
      chk("restart", n_em, 1);
      // report+disconnect: switches held off while pins move
      bus(1'b1, 4'h0, 32'h0000_0005);
      tick(4);
      mb <= 1'b1;
      tick(6);
      chk("switch_held", {off, byp, hs, mon}, 4'hC);
      bus(1'b1, 4'h0, 32'h0000_0004);
      tick(3);
      chk("reeval2", n_re, 2);
      // sleep to ignore with pins unchanged: quiet resume
      bus(1'b1, 4'h0, 32'h0000_0009);
      tick(4);
      bus(1'b1, 4'h0, 32'h0000_000D);
      tick(3);
      chk("beh_change", outs, 7'h40);
      chk("beh_quiet", n_re + n_em, 4);
      bus(1'b1, 4'h0, 32'h0000_000C);
      // accumulate to 1 mAh, then reset
      bus(1'b1, 4'h4, 32'h0000_0001);
      bus(1'b1, 4'h0, 32'h0000_0001);
      plug <= 1'b1;
      tick(4);
      chk("attach_restart", n_em, 3);
      draw <= 12'hFFF;
      tick(8000);
      chk("not_yet", an, 1'b1);
      n = 0;
      while (an !== 1'b0 && n < 2000)
      begin
         tick(1);
         n++;
      end
      chk("reached", an, 1'b0);
      draw <= 12'h000;
      rchk("accum", 4'hC, 32'h0000_0001);
      bus(1'b1, 4'h0, 32'h0000_0003);
      tick(3);
      chk("alert_rel", an, 1'b1);
      rchk("accum_clr", 4'hC, 32'h0000_0000);
      rchk("flag_clr", 4'h8, 32'h0000_0004);
      // counting restarts from zero, disable clears it
      bus(1'b1, 4'h4, 32'h0000_0002);
      draw <= 12'hFFF;
      tick(9000);
      rchk("resumed", 4'hC, 32'h0000_0001);
      chk("below_limit", an, 1'b1);
      bus(1'b1, 4'h0, 32'h0000_0000);
      draw <= 12'h000;
      rchk("dis_clr", 4'hC, 32'h0000_0000);
      finish_test;
   end
endmodule : testbench
`default_nettype wire
